// ===== hw/blx_defs.vh
`ifndef BLX_DEFS_VH
`define BLX_DEFS_VH
// Purpose: constants for the bit-logic, bit-branch and call execution unit
// Assumes: 8-bit registers, 16-bit program counter and stack pointer
// Notes: register offsets are byte addresses on the axi4-lite slave
`define BLX_OP_BIT_OR 8'h07
`define BLX_OP_BIT_XOR 8'h27
`define BLX_OP_BIT_BR 8'h37
`define BLX_OP_CALL_DIRECT 8'hf6
`define BLX_OP_CALL_PAIR 8'hf4
`define BLX_OP_CALL_VECTOR 8'hd4
`define BLX_CYC_BIT 4'h6
`define BLX_CYC_BRANCH 4'ha
`define BLX_CYC_CALL_DIRECT 4'he
`define BLX_CYC_CALL_PAIR 4'hc
`define BLX_CYC_CALL_VECTOR 4'he
`define BLX_FLG_C 7
`define BLX_FLG_Z 6
`define BLX_FLG_S 5
`define BLX_FLG_V 4
`define BLX_REG_CTRL 8'h00
`define BLX_REG_STAT 8'h04
`define BLX_REG_PC 8'h08
`define BLX_REG_SP 8'h0c
`define BLX_REG_FLAGS 8'h10
`define BLX_REG_IR 8'h14
`define BLX_REG_RFADDR 8'h18
`define BLX_REG_RFDATA 8'h1c
`define BLX_REG_PMADDR 8'h20
`define BLX_REG_PMDATA 8'h24
`define BLX_REG_STKADDR 8'h28
`define BLX_REG_STKDATA 8'h2c
`define BLX_RST_SP 16'h0100
`endif

// ===== hw/blx_exec.v
// Purpose: executes bit or, bit xor, bit-test branches and the three call forms
// Assumes: software loads memories and instruction bytes over axi4-lite
// Notes: one instruction per start; busy spans the instruction's cycle count plus one
// Function
// - bit or: or chosen bit with bit zero, store in chosen destination bit
// - bit xor: xor chosen bit with bit zero, store only in destination bit
// - other destination bits and the source stay unchanged
// - z set if result zero, s cleared, v undefined, c d h kept
// - byte two: 4-bit working reg, 3-bit index, selector picks roles
// - branch on clear adds displacement when tested bit is zero
// - branch on set adds displacement when tested bit is one
// - displacement is signed, reaching +127 to -128
// - branches and calls leave every flag unchanged
// - call pushes low pc byte then high byte, then loads target
// - saved pc is the address after the call, per its length
// - call forms: direct f6, pair indirect f4, vectored d4
// - vectored call reads target from program memory, high byte first
`include "blx_defs.vh"
module blx_exec (
   input wire i_mclk,
   input wire i_rst,
   input wire i_ce,
   input wire [7:0] i_awaddr,
   input wire i_awvalid,
   output wire o_awready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   output wire o_wready,
   output wire [1:0] o_bresp,
   output wire o_bvalid,
   input wire i_bready,
   input wire [7:0] i_araddr,
   input wire i_arvalid,
   output wire o_arready,
   output reg [31:0] o_rdata,
   output wire [1:0] o_rresp,
   output wire o_rvalid,
   input wire i_rready,
   output wire o_busy
);
   localparam ST_IDLE = 4'b0001;
   localparam ST_RD = 4'b0010;
   localparam ST_WAIT = 4'b0100;
   localparam ST_DONE = 4'b1000;
   reg [3:0] st_reg;
   reg [15:0] pc_reg, sp_reg;
   reg [7:0] flags_reg;
   reg [23:0] ir_reg;
   reg [7:0] rfa_reg;
   reg [15:0] pma_reg, stka_reg;
   reg [3:0] cyc_reg;
   reg [1:0] step_reg;
   reg [7:0] hi_reg, lo_reg;
   reg aw_reg, w_reg, b_reg, r_reg;
   reg [7:0] awa_reg;
   reg [31:0] wd_reg;
   reg [3:0] ws_reg;
   // memory ports
   reg rf_we, pm_we, sk_we;
   reg [7:0] rf_wa, rf_ra, rf_wd, sk_wd;
   reg [15:0] pm_wa, pm_ra, sk_wa;
   wire [7:0] rf_rd, pm_rd, sk_rd;
   blx_mem #(.AW(8)) u_rf (.i_mclk(i_mclk), .i_ce(i_ce), .i_we(rf_we), .i_waddr(rf_wa),
      .i_wdata(rf_wd), .i_raddr(rf_ra), .o_rdata(rf_rd));
   blx_mem #(.AW(16)) u_pm (.i_mclk(i_mclk), .i_ce(i_ce), .i_we(pm_we), .i_waddr(pm_wa),
      .i_wdata(wd_reg[7:0]), .i_raddr(pm_ra), .o_rdata(pm_rd));
   blx_mem #(.AW(16)) u_sk (.i_mclk(i_mclk), .i_ce(i_ce), .i_we(sk_we), .i_waddr(sk_wa),
      .i_wdata(sk_wd), .i_raddr(stka_reg), .o_rdata(sk_rd));
   // instruction fields
   wire [7:0] opc = ir_reg[23:16];
   wire [3:0] wreg = ir_reg[15:12];
   wire [2:0] bidx = ir_reg[11:9];
   wire sel = ir_reg[8];
   wire [7:0] b3 = ir_reg[7:0];
   wire [7:0] work_addr = {4'h0, wreg};
   // working register address for rr pair in second byte
   wire [7:0] pair_addr = {ir_reg[15:9], 1'b0};
   wire is_bit = (opc == `BLX_OP_BIT_OR) || (opc == `BLX_OP_BIT_XOR);
   wire is_call = (opc == `BLX_OP_CALL_DIRECT) || (opc == `BLX_OP_CALL_PAIR) ||
      (opc == `BLX_OP_CALL_VECTOR);
   wire known = is_bit || is_call || (opc == `BLX_OP_BIT_BR);
   // two-byte calls return to pc+2, direct call to pc+3
   wire [15:0] len = (opc == `BLX_OP_CALL_PAIR || opc == `BLX_OP_CALL_VECTOR) ? 16'h0002 :
      16'h0003;
   wire [15:0] ret_pc = pc_reg + len;
   wire [3:0] cyc_total = is_bit ? `BLX_CYC_BIT :
      (opc == `BLX_OP_BIT_BR) ? `BLX_CYC_BRANCH :
      (opc == `BLX_OP_CALL_PAIR) ? `BLX_CYC_CALL_PAIR :
      (opc == `BLX_OP_CALL_VECTOR) ? `BLX_CYC_CALL_VECTOR : `BLX_CYC_CALL_DIRECT;
   // step 0 reads operand a, step 1 operand b; hi holds the working reg, lo the other
   // sel=0: dst is working reg bit 0, src is reg b3 bit b
   wire src_bit = sel ? hi_reg[0] : lo_reg[bidx];
   wire dst_bit = sel ? lo_reg[bidx] : hi_reg[0];
   wire res_bit = (opc == `BLX_OP_BIT_OR) ? (dst_bit | src_bit) : (dst_bit ^ src_bit);
   wire [7:0] dst_val = sel ? lo_reg : hi_reg;
   reg [7:0] new_dst;
   always @* begin
      new_dst = dst_val;
      if (sel) begin
         new_dst[bidx] = res_bit;
      end else begin
         new_dst[0] = res_bit;
      end
   end
   wire tested = hi_reg[bidx];
   wire taken = sel ? tested : ~tested;
   wire [15:0] disp = {{8{b3[7]}}, b3};
   wire wr_go = aw_reg && w_reg && !b_reg;
   wire start = wr_go && (awa_reg == `BLX_REG_CTRL) && wd_reg[0] && (st_reg == ST_IDLE);
   assign o_busy = (st_reg != ST_IDLE);
   assign o_awready = !aw_reg && !b_reg;
   assign o_wready = !w_reg && !b_reg;
   assign o_bvalid = b_reg;
   assign o_bresp = 2'b00;
   assign o_rvalid = r_reg;
   assign o_rresp = 2'b00;
   assign o_arready = !r_reg;
   // memory port steering
   always @* begin
      rf_we = 1'b0;
      rf_wa = rfa_reg;
      rf_wd = wd_reg[7:0];
      rf_ra = rfa_reg;
      pm_we = wr_go && (awa_reg == `BLX_REG_PMDATA);
      pm_wa = pma_reg;
      pm_ra = pma_reg;
      sk_we = 1'b0;
      sk_wa = stka_reg;
      sk_wd = wd_reg[7:0];
      if (wr_go && awa_reg == `BLX_REG_RFDATA) begin
         rf_we = 1'b1;
      end
      if (wr_go && awa_reg == `BLX_REG_STKDATA) begin
         sk_we = 1'b1;
      end
      if (st_reg == ST_RD) begin
         rf_ra = (step_reg == 2'd0) ? (is_call ? pair_addr : work_addr) :
            (is_call ? pair_addr + 8'h01 : b3);
         // vector table address is the second byte of the two-byte call
         pm_ra = (step_reg == 2'd0) ? {8'h00, ir_reg[15:8]} :
            {8'h00, ir_reg[15:8]} + 16'h0001;
      end
      if (st_reg == ST_WAIT && cyc_reg == 4'd2 && is_bit) begin
         rf_we = 1'b1;
         rf_wa = sel ? b3 : work_addr;
         rf_wd = new_dst;
      end
      if (st_reg == ST_WAIT && is_call && cyc_reg == 4'd3) begin
         sk_we = 1'b1;
         sk_wa = sp_reg - 16'h0001;
         sk_wd = ret_pc[7:0];
      end
      if (st_reg == ST_WAIT && is_call && cyc_reg == 4'd2) begin
         sk_we = 1'b1;
         sk_wa = sp_reg - 16'h0001;
         sk_wd = ret_pc[15:8];
      end
   end
   // operand fetch, count-down and commit
   always @(posedge i_mclk) begin
      if (i_rst) begin
         st_reg <= ST_IDLE;
         pc_reg <= 16'h0000;
         sp_reg <= `BLX_RST_SP;
         flags_reg <= 8'h00;
         ir_reg <= 24'h000000;
         step_reg <= 2'd0;
         cyc_reg <= 4'd0;
         hi_reg <= 8'h00;
         lo_reg <= 8'h00;
      end else if (i_ce) begin
         case (st_reg)
            ST_IDLE: begin
               // unknown opcodes never leave idle, so they have no effect
               if (start && known) begin
                  st_reg <= ST_RD;
                  step_reg <= 2'd0;
                  cyc_reg <= cyc_total;
               end
            end
            ST_RD: begin
               cyc_reg <= cyc_reg - 4'd1;
               step_reg <= step_reg + 2'd1;
               if (step_reg == 2'd1) begin
                  hi_reg <= (opc == `BLX_OP_CALL_VECTOR) ? pm_rd : rf_rd;
               end
               if (step_reg == 2'd2) begin
                  lo_reg <= (opc == `BLX_OP_CALL_VECTOR) ? pm_rd : rf_rd;
                  st_reg <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               cyc_reg <= cyc_reg - 4'd1;
               if (is_call && (cyc_reg == 4'd3 || cyc_reg == 4'd2)) begin
                  sp_reg <= sp_reg - 16'h0001;
               end
               if (cyc_reg == 4'd1) begin
                  st_reg <= ST_DONE;
                  if (is_bit) begin
                     flags_reg[`BLX_FLG_Z] <= ~res_bit;
                     flags_reg[`BLX_FLG_S] <= 1'b0;
                     // v is undefined here; it is left as it was
                  end
                  // no flag update for branches and calls
                  if (opc == `BLX_OP_BIT_BR) begin
                     pc_reg <= taken ? ret_pc + disp : ret_pc;
                  end else if (opc == `BLX_OP_CALL_DIRECT) begin
                     pc_reg <= {ir_reg[15:8], b3};
                  end else if (is_call) begin
                     pc_reg <= {hi_reg, lo_reg};
                  end else begin
                     pc_reg <= ret_pc;
                  end
               end
            end
            ST_DONE: begin
               st_reg <= ST_IDLE;
            end
            default: begin
               st_reg <= ST_IDLE;
            end
         endcase
         if (wr_go && st_reg == ST_IDLE && !start) begin
            if (awa_reg == `BLX_REG_PC) pc_reg <= wd_reg[15:0];
            if (awa_reg == `BLX_REG_SP) sp_reg <= wd_reg[15:0];
            if (awa_reg == `BLX_REG_FLAGS) flags_reg <= wd_reg[7:0];
            if (awa_reg == `BLX_REG_IR) ir_reg <= wd_reg[23:0];
         end
      end
   end
   // axi4-lite channels
   always @(posedge i_mclk) begin
      if (i_rst) begin
         aw_reg <= 1'b0;
         w_reg <= 1'b0;
         b_reg <= 1'b0;
         r_reg <= 1'b0;
         awa_reg <= 8'h00;
         wd_reg <= 32'h00000000;
         ws_reg <= 4'h0;
         rfa_reg <= 8'h00;
         pma_reg <= 16'h0000;
         stka_reg <= 16'h0000;
         o_rdata <= 32'h00000000;
      end else if (i_ce) begin
         if (i_awvalid && o_awready) begin
            aw_reg <= 1'b1;
            awa_reg <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_reg <= 1'b1;
            wd_reg <= i_wdata;
            ws_reg <= i_wstrb;
         end
         if (wr_go) begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            b_reg <= 1'b1;
            if (awa_reg == `BLX_REG_RFADDR) rfa_reg <= wd_reg[7:0];
            if (awa_reg == `BLX_REG_PMADDR) pma_reg <= wd_reg[15:0];
            if (awa_reg == `BLX_REG_STKADDR) stka_reg <= wd_reg[15:0];
            // program-memory data writes step the pointer so bytes can be streamed
            if (awa_reg == `BLX_REG_PMDATA) pma_reg <= pma_reg + 16'h0001;
         end else if (b_reg && i_bready) begin
            b_reg <= 1'b0;
         end
         if (i_arvalid && o_arready) begin
            r_reg <= 1'b1;
            case (i_araddr)
               `BLX_REG_STAT: o_rdata <= {27'h0, st_reg, o_busy};
               `BLX_REG_PC: o_rdata <= {16'h0, pc_reg};
               `BLX_REG_SP: o_rdata <= {16'h0, sp_reg};
               `BLX_REG_FLAGS: o_rdata <= {24'h0, flags_reg};
               `BLX_REG_IR: o_rdata <= {8'h0, ir_reg};
               `BLX_REG_RFADDR: o_rdata <= {24'h0, rfa_reg};
               `BLX_REG_RFDATA: o_rdata <= {24'h0, rf_rd};
               `BLX_REG_PMADDR: o_rdata <= {16'h0, pma_reg};
               `BLX_REG_PMDATA: o_rdata <= {24'h0, pm_rd};
               `BLX_REG_STKADDR: o_rdata <= {16'h0, stka_reg};
               `BLX_REG_STKDATA: o_rdata <= {24'h0, sk_rd};
               default: o_rdata <= 32'h00000000;
            endcase
         end else if (r_reg && i_rready) begin
            r_reg <= 1'b0;
         end
      end
   end
endmodule // blx_exec

// ===== hw/blx_mem.v
// Purpose: byte memory used for register file, program memory and stack
// Assumes: one write port, one read port, read data registered
// Notes: contents are not cleared by reset
module blx_mem #(
   parameter AW = 8
) (
   input wire i_mclk,
   input wire i_ce,
   input wire i_we,
   input wire [AW-1:0] i_waddr,
   input wire [7:0] i_wdata,
   input wire [AW-1:0] i_raddr,
   output reg [7:0] o_rdata
);
   reg [7:0] mem [0:(1<<AW)-1];
   always @(posedge i_mclk) begin
      if (i_ce) begin
         if (i_we) begin
            mem[i_waddr] <= i_wdata;
         end
         o_rdata <= mem[i_raddr];
      end
   end
endmodule // blx_mem

// ===== tb/blx_exec_properties.sv
// Purpose: port timing and handshake checks for blx_exec
// Assumes: busy spans the instruction cycle count plus a small fixed overhead
// Notes: attached to every blx_exec instance by the bind below
module blx_exec_chk (
   input wire i_mclk,
   input wire i_rst,
   input wire i_ce,
   input wire i_arvalid,
   input wire o_arready,
   input wire [1:0] o_bresp,
   input wire o_bvalid,
   input wire i_bready,
   input wire [1:0] o_rresp,
   input wire o_rvalid,
   input wire i_rready,
   input wire o_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_mclk); endclocking
   // a frozen clock enable stretches every timing, so checks pause with it
   default disable iff (i_rst || !i_ce);
   chk_bresp_okay: assert property (o_bvalid |-> o_bresp == 2'b00) else $error("bresp not okay");
   chk_rresp_okay: assert property (o_rvalid |-> o_rresp == 2'b00) else $error("rresp not okay");
   chk_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
      else $error("bvalid dropped early");
   chk_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid)
      else $error("rvalid dropped early");
   chk_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   chk_reset_idle: assert property (disable iff (1'b0) i_rst |=> !o_busy && !o_bvalid)
      else $error("not idle in reset");
   // shortest instruction is the six-cycle bit operation
   chk_busy_min_len: assert property ($rose(o_busy) |-> o_busy[*6])
      else $error("busy too short");
   // longest call is fourteen cycles; overhead is small
   chk_busy_max_len: assert property ($rose(o_busy) |-> ##[6:20] !o_busy)
      else $error("busy too long");
endmodule // blx_exec_chk

bind blx_exec blx_exec_chk u_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
   .i_arvalid(i_arvalid),
   .o_arready(o_arready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
   .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_busy(o_busy));

// ===== tb/blx_pm_img.sv
// Purpose: program-memory image for the vectored call table entry
// Assumes: bench copies the bytes into program memory over the register bus
// Notes: target value is arbitrary
module blx_pm_img #(
   parameter logic [15:0] VEC_TARGET = 16'h3521
) (
   output wire [7:0] o_vec_hi,
   output wire [7:0] o_vec_lo
);
   timeunit 1ns;
   timeprecision 1ps;
   assign o_vec_hi = VEC_TARGET[15:8];
   assign o_vec_lo = VEC_TARGET[7:0];
endmodule // blx_pm_img

// ===== tb/tb_bit_logic_branch_call_exec.sv
// Purpose: self-checking bench for blx_exec
// Assumes: memories loaded through the axi4-lite slave
// Notes: v is undefined after bit operations, so it is masked
`include "blx_defs.vh"
module tb_bit_logic_branch_call_exec;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 0, i_rst = 1, i_ce = 1;
   logic [7:0] aw = 8'h00, ar = 8'h00;
   logic [31:0] wd = 32'h0, d;
   logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
   wire awr, wrr, bv, arr, rv, busy;
   wire [1:0] br, rr;
   wire [31:0] rdat;
   wire [7:0] vh, vl;
   int bad_count = 0, n_tests = 0, cyc = 0;
   // {ir, r1, r5, r1 after, r5 after, c z s after}
   logic [63:0] rows [6] = '{64'h071205_07_03_07_03_80, 64'h271205_07_03_06_03_c0,
      64'h071505_07_03_07_07_80, 64'h271505_07_03_07_07_80,
      64'h271f05_01_80_01_00_c0, 64'h071905_00_ef_00_ef_c0};
   // {ir, r1, pc after} from pc 1000
   logic [47:0] brs [3] = '{48'h371680_07_0f83, 48'h371780_07_1003, 48'h37137f_07_1082};
   logic [31:0] cls [3] = '{32'hf63521_4a, 32'hf40000_49, 32'hd44000_49};
   blx_exec u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_awaddr(aw), .i_awvalid(awv),
      .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wrr),
      .o_bresp(br), .o_bvalid(bv), .i_bready(bre), .i_araddr(ar), .i_arvalid(arv),
      .o_arready(arr), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv), .i_rready(rre),
      .o_busy(busy));
   blx_pm_img u_pm (.o_vec_hi(vh), .o_vec_lo(vl));
   initial begin
      forever #2 i_mclk = ~i_mclk;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 8000) begin
         bad_count++;
         end_sim;
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_mclk);
      aw <= a;
      wd <= v;
      awv <= 1;
      wv <= 1;
      bre <= 1;
      do begin
         @(posedge i_mclk);
         if (awv && awr) awv <= 0;
         if (wv && wrr) wv <= 0;
      end while (bv !== 1'b1);
      bre <= 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_mclk);
      ar <= a;
      arv <= 1;
      rre <= 1;
      do begin
         @(posedge i_mclk);
         if (arv && arr) arv <= 0;
      end while (rv !== 1'b1);
      v = rdat;
      rre <= 0;
   endtask
   // memory data is registered, so the second read sees the new address
   task automatic mrd(input logic [7:0] ptr, input logic [7:0] a, output logic [31:0] v);
      wr(ptr, {24'h0, a});
      rd(ptr + 8'h04, v);
      rd(ptr + 8'h04, v);
   endtask
   task automatic rfw(input logic [7:0] a, input logic [7:0] v);
      wr(`BLX_REG_RFADDR, {24'h0, a});
      wr(`BLX_REG_RFDATA, {24'h0, v});
   endtask
   task automatic go(input logic [23:0] ir, input logic [15:0] pc, input logic [7:0] fl,
      input int hold = 0);
      wr(`BLX_REG_PC, {16'h0, pc});
      wr(`BLX_REG_SP, 32'h2);
      wr(`BLX_REG_FLAGS, {24'h0, fl});
      wr(`BLX_REG_IR, {8'h00, ir});
      wr(`BLX_REG_CTRL, 32'h1);
      while (busy !== 1'b1) @(posedge i_mclk);
      // a freeze longer than any instruction proves the enable stops all state
      if (hold > 0) begin
         i_ce <= 0;
         repeat (hold) @(posedge i_mclk);
         chk("ce_freeze", 32'h1, {31'h0, busy});
         i_ce <= 1;
      end
      while (busy !== 1'b0) @(posedge i_mclk);
   endtask
   initial begin
      repeat (20) @(posedge i_mclk);
      i_rst <= 0;
      rd(`BLX_REG_PC, d);
      chk("pc_rst", 32'h0, d);
      rd(`BLX_REG_SP, d);
      chk("sp_rst", 32'h100, d);
      rd(8'h30, d);
      chk("unmapped", 32'h0, d);
      foreach (rows[i]) begin
         rfw(8'h01, rows[i][39:32]);
         rfw(8'h05, rows[i][31:24]);
         go(rows[i][63:40], 16'h1000, 8'hac);
         mrd(`BLX_REG_RFADDR, 8'h01, d);
         chk("wreg", {24'h0, rows[i][23:16]}, d);
         mrd(`BLX_REG_RFADDR, 8'h05, d);
         chk("breg", {24'h0, rows[i][15:8]}, d);
         rd(`BLX_REG_FLAGS, d);
         chk("flags", {24'h0, rows[i][7:0] | 8'h0c}, d & 32'hef);
      end
      foreach (brs[i]) begin
         rfw(8'h01, brs[i][23:16]);
         go(brs[i][47:24], 16'h1000, 8'hf0);
         rd(`BLX_REG_PC, d);
         chk("br_pc", {16'h0, brs[i][15:0]}, d);
         rd(`BLX_REG_FLAGS, d);
         chk("br_flags", 32'hf0, d);
      end
      rfw(8'h00, 8'h35);
      rfw(8'h01, 8'h21);
      wr(`BLX_REG_PMADDR, 32'h40);
      wr(`BLX_REG_PMDATA, {24'h0, vh});
      wr(`BLX_REG_PMDATA, {24'h0, vl});
      foreach (cls[i]) begin
         // clear the stack bytes so each call must push its own values
         wr(`BLX_REG_STKADDR, 32'h0);
         wr(`BLX_REG_STKDATA, 32'h0);
         wr(`BLX_REG_STKADDR, 32'h1);
         wr(`BLX_REG_STKDATA, 32'h0);
         go(cls[i][31:8], 16'h1a47, 8'hf0, (i == 2) ? 20 : 0);
         rd(`BLX_REG_PC, d);
         chk("call_pc", 32'h3521, d);
         rd(`BLX_REG_SP, d);
         chk("call_sp", 32'h0, d);
         mrd(`BLX_REG_STKADDR, 8'h00, d);
         chk("stk_hi", 32'h1a, d);
         mrd(`BLX_REG_STKADDR, 8'h01, d);
         chk("stk_lo", {24'h0, cls[i][7:0]}, d);
         rd(`BLX_REG_FLAGS, d);
         chk("call_flags", 32'hf0, d);
      end
      // an unknown opcode must not start anything
      wr(`BLX_REG_PC, 32'h1234);
      wr(`BLX_REG_IR, 32'h00ff0000);
      wr(`BLX_REG_CTRL, 32'h1);
      repeat (4) @(posedge i_mclk);
      chk("unk_busy", 32'h0, {31'h0, busy});
      rd(`BLX_REG_PC, d);
      chk("unk_pc", 32'h1234, d);
      // reset while idle returns the visible state to its reset values
      i_rst <= 1;
      repeat (2) @(posedge i_mclk);
      i_rst <= 0;
      chk("busy_rst", 32'h0, {31'h0, busy});
      rd(`BLX_REG_FLAGS, d);
      chk("flags_rst", 32'h0, d);
      rd(`BLX_REG_PC, d);
      chk("pc_rst2", 32'h0, d);
      rd(`BLX_REG_SP, d);
      chk("sp_rst2", 32'h100, d);
      end_sim;
   end
endmodule // tb_bit_logic_branch_call_exec
